// ---- brtc_core.sv ----
// real-time clock with calendar, snapshot latch, periodic and alarm interrupts
// assumes a classic Wishbone master on clk_sys and a crystal clock on a pin
//
// How it works
// - eight counters from hundredths to years are each readable and writable.
// - data moves over an 8-bit path whose enable is high only while read data is driven.
// - the count pulse divides the crystal clock, of four frequencies picked by a command field.
// - in multiplexed mode the address is captured from the data path on the latch strobe.
// - a periodic interrupt fires at one of six rates picked by the rate register.
// - an alarm memory loaded by the host feeds a comparator that drives the interrupt.
// - the alarm fires when the running counters equal the alarm memory.
// - a readable status register tells whether periodic or alarm raised the interrupt.
// - while power fails, bus reads and writes are ignored but time and interrupts go on.
// - a hundredths read copies every counter into a latch that later reads of the other counters return.
// - hours run in 12-hour or 24-hour form as a command bit chooses.
// - the calendar knows month lengths and leap-year Februaries.
// - the year counter runs from 0 to 99.
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module brtc_core
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [6:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic dataOe,
   input wire logic addrLatch,
   input wire logic xtalClk,
   input wire logic powerFail,
   output logic irq
);
   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic xtalMeta, xtalSync, xtalPrev, pfMeta, pfSync;
   always_ff @(posedge clk_sys)
   begin
      xtalMeta <= xtalClk;
      xtalSync <= xtalMeta;
      xtalPrev <= xtalSync;
      pfMeta <= powerFail;
      pfSync <= pfMeta;
   end
   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [7:0] count [8];
   logic [7:0] snap [8];
   logic [7:0] alarm [8];
   logic [7:0] command;
   logic [2:0] rate;
   logic [1:0] status, enable;
   logic [6:0] muxAddr;
   logic [22:0] accum;
   logic hundTick, matchPrev;
   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   logic req, wrStrobe, rdStrobe, byteWr;
   logic [6:0] addr;
   logic [7:0] wrByte;
   logic [2:0] sel3;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign addr = command[brtc_pkg::CMD_MUXED] ? muxAddr : wb_adr_i;
   assign byteWr = wb_sel_i[0];
   assign wrByte = wb_dat_i[7:0];
   assign wrStrobe = req && wb_we_i && byteWr && !pfSync;
   assign rdStrobe = req && !wb_we_i && !pfSync;
   assign sel3 = addr[4:2];

   // latch strobe captures the address from the low data lines
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         muxAddr <= 7'h00;
      else if (addrLatch)
         muxAddr <= wb_dat_i[6:0];
   end
   // ------------------------------------------------------------------
   // crystal divider: fractional accumulator gives an exact 100 Hz pulse
   // ------------------------------------------------------------------
   logic [22:0] xtalHz;
   logic [23:0] accSum;
   always_comb
   begin
      case (command[brtc_pkg::CMD_XTAL_LO +: 2])
         2'h0: xtalHz = brtc_pkg::XTAL_HZ_0;
         2'h1: xtalHz = brtc_pkg::XTAL_HZ_1;
         2'h2: xtalHz = brtc_pkg::XTAL_HZ_2;
         default: xtalHz = brtc_pkg::XTAL_HZ_3;
      endcase
   end
   assign accSum = {1'b0, accum} + {1'b0, brtc_pkg::TICK_HZ};
   always_ff @(posedge clk_sys)
   begin
      hundTick <= 1'b0;
      if (srst || !command[brtc_pkg::CMD_RUN])
         accum <= 23'h000000;
      else if (xtalSync && !xtalPrev)
      begin
         if (accSum >= {1'b0, xtalHz})
         begin
            accum <= 23'(accSum - {1'b0, xtalHz});
            hundTick <= 1'b1;
         end
         else
            accum <= accSum[22:0];
      end
   end
   // ------------------------------------------------------------------
   // calendar helpers
   // ------------------------------------------------------------------
   function automatic logic [7:0] brtc_days(input logic [7:0] month, input logic [7:0] year);
      logic [7:0] d;
      d = 8'h1F;
      case (month)
         8'h02: d = (year[1:0] == 2'h0) ? 8'h1D : 8'h1C;
         8'h04, 8'h06, 8'h09, 8'h0B: d = 8'h1E;
         default: d = 8'h1F;
      endcase
      return d;
   endfunction

   // 24-hour internal hour to the host's view
   function automatic logic [7:0] brtc_hour_out(input logic [7:0] h, input logic mode24);
      logic [7:0] r;
      r = h;
      if (!mode24)
      begin
         if (h == 8'h00)
            r = brtc_pkg::NOON;
         else if (h > brtc_pkg::NOON)
            r = 8'(h - brtc_pkg::NOON);
         r[brtc_pkg::HOUR_PM] = (h >= brtc_pkg::NOON);
      end
      return r;
   endfunction

   // host's view of an hour to the 24-hour internal form
   function automatic logic [7:0] brtc_hour_in(input logic [7:0] v, input logic mode24);
      logic [7:0] h;
      h = {3'h0, v[4:0]};
      if (!mode24)
      begin
         if (h == brtc_pkg::NOON)
            h = 8'h00;
         if (v[brtc_pkg::HOUR_PM])
            h = 8'(h + brtc_pkg::NOON);
      end
      return h;
   endfunction
   // ------------------------------------------------------------------
   // time counters and their carry chain
   // ------------------------------------------------------------------
   logic carrySec, carryMin, carryHour, carryDay;
   logic [7:0] dim;
   assign dim = brtc_days(count[brtc_pkg::IDX_MONTH], count[brtc_pkg::IDX_YEAR]);
   assign carrySec = hundTick && count[brtc_pkg::IDX_HUND] == brtc_pkg::MAX_HUND;
   assign carryMin = carrySec && count[brtc_pkg::IDX_SEC] == brtc_pkg::MAX_SEC;
   assign carryHour = carryMin && count[brtc_pkg::IDX_MIN] == brtc_pkg::MAX_SEC;
   assign carryDay = carryHour && count[brtc_pkg::IDX_HOUR] == brtc_pkg::MAX_HOUR;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         for (int i = 0; i < 8; i++)
            count[i] <= 8'h00;
         count[brtc_pkg::IDX_MONTH] <= brtc_pkg::RST_MONTH;
         count[brtc_pkg::IDX_DATE] <= brtc_pkg::RST_DATE;
      end
      else if (wrStrobe && addr < brtc_pkg::OFS_ALARM)
      begin
         // a host write wins over counting in that cycle
         if (sel3 == 3'(brtc_pkg::IDX_HOUR))
            count[sel3] <= brtc_hour_in(wrByte, command[brtc_pkg::CMD_MODE24]);
         else
            count[sel3] <= wrByte;
      end
      else if (hundTick)
      begin
         count[brtc_pkg::IDX_HUND] <= carrySec ? 8'h00 : 8'(count[brtc_pkg::IDX_HUND] + 8'h01);
         if (carrySec)
            count[brtc_pkg::IDX_SEC] <= carryMin ? 8'h00 : 8'(count[brtc_pkg::IDX_SEC] + 8'h01);
         if (carryMin)
            count[brtc_pkg::IDX_MIN] <= carryHour ? 8'h00 : 8'(count[brtc_pkg::IDX_MIN] + 8'h01);
         if (carryHour)
            count[brtc_pkg::IDX_HOUR] <= carryDay ? 8'h00 : 8'(count[brtc_pkg::IDX_HOUR] + 8'h01);
         if (carryDay)
         begin
            count[brtc_pkg::IDX_DOW] <= (count[brtc_pkg::IDX_DOW] >= brtc_pkg::MAX_DOW) ? 8'h00
               : 8'(count[brtc_pkg::IDX_DOW] + 8'h01);
            if (count[brtc_pkg::IDX_DATE] >= dim)
            begin
               count[brtc_pkg::IDX_DATE] <= 8'h01;
               if (count[brtc_pkg::IDX_MONTH] >= brtc_pkg::MAX_MONTH)
               begin
                  count[brtc_pkg::IDX_MONTH] <= 8'h01;
                  count[brtc_pkg::IDX_YEAR] <= (count[brtc_pkg::IDX_YEAR] >= brtc_pkg::MAX_YEAR)
                     ? 8'h00 : 8'(count[brtc_pkg::IDX_YEAR] + 8'h01);
               end
               else
                  count[brtc_pkg::IDX_MONTH] <= 8'(count[brtc_pkg::IDX_MONTH] + 8'h01);
            end
            else
               count[brtc_pkg::IDX_DATE] <= 8'(count[brtc_pkg::IDX_DATE] + 8'h01);
         end
      end
   end
   // ------------------------------------------------------------------
   // snapshot latch
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         for (int i = 0; i < 8; i++)
            snap[i] <= 8'h00;
      end
      else if (rdStrobe && addr == brtc_pkg::OFS_HUND)
      begin
         for (int i = 0; i < 8; i++)
            snap[i] <= count[i];
      end
   end
   // ------------------------------------------------------------------
   // alarm memory and comparator
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         for (int i = 0; i < 8; i++)
            alarm[i] <= 8'h00;
      end
      else if (wrStrobe && addr[6:5] == 2'h1)
      begin
         if (sel3 == 3'(brtc_pkg::IDX_HOUR))
            alarm[sel3] <= brtc_hour_in(wrByte, command[brtc_pkg::CMD_MODE24]);
         else
            alarm[sel3] <= wrByte;
      end
   end

   logic match, alarmEvent;
   always_comb
   begin
      match = 1'b1;
      for (int i = 0; i < 8; i++)
         if (count[i] != alarm[i])
            match = 1'b0;
   end
   assign alarmEvent = match && !matchPrev;
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         matchPrev <= 1'b1;
      else
         matchPrev <= match;
   end
   // ------------------------------------------------------------------
   // periodic event selection
   // ------------------------------------------------------------------
   logic tenthTick, periodicEvent;
   // tenths follow the hundredths count, so a written time keeps them aligned
   assign tenthTick = hundTick
      && count[brtc_pkg::IDX_HUND] % 8'h0A == {4'h0, brtc_pkg::TENTH_COUNT};
   always_comb
   begin
      case (brtc_pkg::brtc_rate_t'(rate))
         brtc_pkg::RATE_HUND: periodicEvent = hundTick;
         brtc_pkg::RATE_TENTH: periodicEvent = tenthTick;
         brtc_pkg::RATE_SEC: periodicEvent = carrySec;
         brtc_pkg::RATE_MIN: periodicEvent = carryMin;
         brtc_pkg::RATE_HOUR: periodicEvent = carryHour;
         brtc_pkg::RATE_DAY: periodicEvent = carryDay;
         default: periodicEvent = 1'b0;
      endcase
   end
   // ------------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         command <= brtc_pkg::RST_COMMAND;
         rate <= brtc_pkg::RST_RATE;
         enable <= brtc_pkg::RST_ENABLE;
      end
      else if (wrStrobe)
      begin
         if (addr == brtc_pkg::OFS_COMMAND)
            command <= {3'h0, wrByte[4:0]};
         if (addr == brtc_pkg::OFS_RATE)
            rate <= wrByte[2:0];
         if (addr == brtc_pkg::OFS_ENABLE)
            enable <= wrByte[1:0];
      end
   end
   // ------------------------------------------------------------------
   // interrupt status: set wins over clear
   // ------------------------------------------------------------------
   logic [1:0] clearMask, setMask;
   assign clearMask = (wrStrobe && addr == brtc_pkg::OFS_CLEAR) ? wrByte[1:0] : 2'h0;
   assign setMask = {periodicEvent, alarmEvent};
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         status <= 2'h0;
      else
         status <= (status & ~clearMask) | setMask;
   end
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         irq <= 1'b0;
      else
         irq <= |(status & enable);
   end
   // ------------------------------------------------------------------
   // bus answer
   // ------------------------------------------------------------------
   logic [7:0] rdByte;
   always_comb
   begin
      rdByte = 8'h00;
      if (addr == brtc_pkg::OFS_HUND)
         rdByte = count[brtc_pkg::IDX_HUND];
      else if (addr < brtc_pkg::OFS_ALARM)
         rdByte = (sel3 == 3'(brtc_pkg::IDX_HOUR))
            ? brtc_hour_out(snap[sel3], command[brtc_pkg::CMD_MODE24]) : snap[sel3];
      else if (addr[6:5] == 2'h1)
         rdByte = (sel3 == 3'(brtc_pkg::IDX_HOUR))
            ? brtc_hour_out(alarm[sel3], command[brtc_pkg::CMD_MODE24]) : alarm[sel3];
      else if (addr == brtc_pkg::OFS_STATUS)
         rdByte = {status != 2'h0, 5'h00, status};
      else if (addr == brtc_pkg::OFS_ENABLE)
         rdByte = {6'h00, enable};
      else if (addr == brtc_pkg::OFS_COMMAND)
         rdByte = command;
      else if (addr == brtc_pkg::OFS_RATE)
         rdByte = {5'h00, rate};
   end
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         dataOe <= 1'b0;
      end
      else
      begin
         wb_ack_o <= req;
         dataOe <= rdStrobe;
         wb_dat_o <= rdStrobe ? {24'h000000, rdByte} : 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// ---- brtc_pkg.sv ----
// constants shared by the real-time clock block: register map, field layout,
// reset values and counter limits
// assumes a 32-bit classic Wishbone register bus with word-aligned registers
`default_nettype none
package brtc_pkg;
   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [6:0] OFS_HUND = 7'h00;
   localparam logic [6:0] OFS_HOUR = 7'h04;
   localparam logic [6:0] OFS_MIN = 7'h08;
   localparam logic [6:0] OFS_SEC = 7'h0C;
   localparam logic [6:0] OFS_MONTH = 7'h10;
   localparam logic [6:0] OFS_DATE = 7'h14;
   localparam logic [6:0] OFS_YEAR = 7'h18;
   localparam logic [6:0] OFS_DOW = 7'h1C;
   localparam logic [6:0] OFS_ALARM = 7'h20;
   localparam logic [6:0] OFS_STATUS = 7'h40;
   localparam logic [6:0] OFS_CLEAR = 7'h44;
   localparam logic [6:0] OFS_ENABLE = 7'h48;
   localparam logic [6:0] OFS_COMMAND = 7'h4C;
   localparam logic [6:0] OFS_RATE = 7'h50;
   // ------------------------------------------------------------------
   // counter indices
   // ------------------------------------------------------------------
   localparam int IDX_HUND = 0;
   localparam int IDX_HOUR = 1;
   localparam int IDX_MIN = 2;
   localparam int IDX_SEC = 3;
   localparam int IDX_MONTH = 4;
   localparam int IDX_DATE = 5;
   localparam int IDX_YEAR = 6;
   localparam int IDX_DOW = 7;
   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int STAT_ALARM = 0;
   localparam int STAT_PERIODIC = 1;
   localparam int CMD_XTAL_LO = 0;
   localparam int CMD_MODE24 = 2;
   localparam int CMD_RUN = 3;
   localparam int CMD_MUXED = 4;
   localparam int HOUR_PM = 7;
   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_COMMAND = 8'h0C;
   localparam logic [2:0] RST_RATE = 3'h0;
   localparam logic [1:0] RST_ENABLE = 2'h0;
   localparam logic [7:0] RST_MONTH = 8'h01;
   localparam logic [7:0] RST_DATE = 8'h01;
   // ------------------------------------------------------------------
   // crystal choices in Hz and the hundredth-second rate
   // ------------------------------------------------------------------
   localparam logic [22:0] XTAL_HZ_0 = 23'h008000;
   localparam logic [22:0] XTAL_HZ_1 = 23'h100000;
   localparam logic [22:0] XTAL_HZ_2 = 23'h200000;
   localparam logic [22:0] XTAL_HZ_3 = 23'h400000;
   localparam logic [22:0] TICK_HZ = 23'h000064;
   // ------------------------------------------------------------------
   // counter limits and periodic rates
   // ------------------------------------------------------------------
   localparam logic [7:0] MAX_HUND = 8'h63;
   localparam logic [7:0] MAX_SEC = 8'h3B;
   localparam logic [7:0] MAX_HOUR = 8'h17;
   localparam logic [7:0] MAX_MONTH = 8'h0C;
   localparam logic [7:0] MAX_YEAR = 8'h63;
   localparam logic [7:0] MAX_DOW = 8'h06;
   localparam logic [7:0] NOON = 8'h0C;
   localparam logic [3:0] TENTH_COUNT = 4'h9;
   typedef enum logic [2:0] {RATE_HUND, RATE_TENTH, RATE_SEC, RATE_MIN, RATE_HOUR,
      RATE_DAY} brtc_rate_t;
endpackage
`default_nettype wire

// ---- brtc_monitor.sv ----
// concurrent checks on the bus answer, data enable, power lockout and interrupt mask
// assumes the master keeps classic single cycles and stays in direct addressing
`timescale 1ns/100ps
`default_nettype none
module brtc_monitor
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [6:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic dataOe,
   input wire logic addrLatch,
   input wire logic xtalClk,
   input wire logic powerFail,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   sequence quietPower;
      !powerFail [*4];
   endsequence
   sequence request;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence readAt(logic [6:0] a);
      quietPower ##0 request ##0 (!wb_we_i && wb_adr_i == a);
   endsequence
   chk_ack_next: assert property (request |=> wb_ack_o)
      else $error("request not answered in one cycle");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   chk_oe_only_read: assert property (dataOe |-> wb_ack_o && !$past(wb_we_i))
      else $error("data enable outside a read answer");
   chk_oe_on_read: assert property (quietPower ##0 request ##0 (!wb_we_i &&
      wb_adr_i <= brtc_pkg::OFS_DOW) |=> dataOe)
      else $error("counter read without data enable");
   chk_pf_mute: assert property (powerFail [*4] ##0 request |=> !dataOe && !wb_dat_o)
      else $error("access answered during power failure");
   chk_dat_idle: assert property (!dataOe |-> wb_dat_o == 32'h0)
      else $error("read data outside a read answer");
   chk_status_any: assert property (readAt(brtc_pkg::OFS_STATUS) |=>
      wb_dat_o[7] == (wb_dat_o[0] || wb_dat_o[1]))
      else $error("status summary bit wrong");
   chk_unmapped_zero: assert property (readAt(7'h60) |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_hund_range: assert property (readAt(brtc_pkg::OFS_HUND) |=>
      wb_dat_o[7:0] <= brtc_pkg::MAX_HUND)
      else $error("hundredths out of range");
   chk_irq_mask: assert property (quietPower ##0 request ##0 (wb_we_i && wb_sel_i[0] &&
      wb_adr_i == brtc_pkg::OFS_ENABLE && wb_dat_i[1:0] == 2'h0) |-> ##3 !irq)
      else $error("interrupt not masked");
endmodule
bind brtc_core brtc_monitor brtc_monitor_inst (.clk_sys(clk_sys), .srst(srst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .dataOe(dataOe), .addrLatch(addrLatch), .xtalClk(xtalClk), .powerFail(powerFail),
   .irq(irq));
`default_nettype wire

// ---- brtc_host.sv ----
// host model: classic single Wishbone cycles and address latch pulses
// assumes the device answers each request with a one-cycle ack on clk_sys
`timescale 1ns/100ps
`default_nettype none
module brtc_host
(
   input wire logic clk_sys,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic dataOe,
   output logic wb_cyc_i,
   output logic wb_stb_i,
   output logic wb_we_i,
   output logic [6:0] wb_adr_i,
   output logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_i,
   output logic addrLatch
);
   initial
   begin
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 7'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
      addrLatch = 1'b0;
   end
   // request held until the edge that samples ack; data taken at that edge
   task automatic wbXfer(input logic [6:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q, output logic oe, output bit ok);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 16);
      q = wb_dat_o;
      oe = dataOe;
      ok = (wb_ack_o === 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_dat_i <= ~d; // released data stops showing the last value
   endtask
   task automatic latchAddr(input logic [6:0] a);
      @(posedge clk_sys);
      addrLatch <= 1'b1;
      wb_dat_i <= {25'h0000000, a};
      @(posedge clk_sys);
      addrLatch <= 1'b0;
      wb_dat_i <= ~{25'h0000000, a};
   endtask
endmodule
`default_nettype wire

// ---- tb_brtc_core.sv ----
// self-checking bench: reset values, counters, calendar roll, interrupts, lockout
// assumes brtc_host drives the register bus; crystal and power pins come from here
`timescale 1ns/100ps
`default_nettype none
module tb_brtc_core;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic xtalClk = 1'b0;
   logic powerFail = 1'b0;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dataOe, addrLatch, irq, oe;
   logic [6:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [23:0] e;
   logic [7:0] v [8];
   logic [7:0] alm [8];
   logic [6:0] rstOfs [6] = '{brtc_pkg::OFS_COMMAND, brtc_pkg::OFS_RATE,
      brtc_pkg::OFS_ENABLE, brtc_pkg::OFS_HUND, brtc_pkg::OFS_MONTH, brtc_pkg::OFS_DATE};
   logic [7:0] rstVal [6] = '{8'h0C, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
   logic [7:0] rollD [6] = '{8'h1C, 8'h1C, 8'h1F, 8'h1E, 8'h1E, 8'h1F};
   logic [7:0] rollM [6] = '{8'h02, 8'h02, 8'h0C, 8'h04, 8'h06, 8'h01};
   logic [7:0] rollY [6] = '{8'h04, 8'h05, 8'h63, 8'h01, 8'h07, 8'h0A};
   logic [5:0] rollH = 6'b010111;
   int fail_count = 0;
   int tests_run = 0;
   always #25 clk_sys = ~clk_sys;
   // crystal at 2.5 MHz, phase unrelated to clk_sys
   initial #37 forever #200 xtalClk = ~xtalClk;
   brtc_core brtc_core_inst (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dataOe(dataOe),
      .addrLatch(addrLatch), .xtalClk(xtalClk), .powerFail(powerFail), .irq(irq));
   brtc_host brtc_host_inst (.clk_sys(clk_sys), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
      .dataOe(dataOe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .addrLatch(addrLatch));
   task automatic give_verdict();
      $display("checks run %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
      input logic [3:0] s);
      bit ok;
      brtc_host_inst.wbXfer(a, w, {24'h000000, d}, s, q, oe, ok);
      check(ok, 1'b1);
      if (!ok)
         give_verdict();
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d, 4'hF);
   endtask
   task automatic rd(input logic [6:0] a);
      xfer(a, 1'b0, 8'h00, 4'hF);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic waitIrq(input int limit);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < limit)
      begin
         @(posedge clk_sys);
         n++;
      end
      check(irq, 1'b1);
      if (irq !== 1'b1)
         give_verdict();
   endtask
   // stop the count, load all eight counters from v
   task automatic setTime(input logic m24);
      wr(brtc_pkg::OFS_COMMAND, {5'h00, m24, 2'h0});
      for (int i = 0; i < 8; i++)
         wr(7'(brtc_pkg::OFS_HUND + 4 * i), v[i]);
   endtask
   function automatic logic [7:0] daysIn(input logic [7:0] m, input logic [7:0] y);
      if (m == 8'h02)
         return (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
      return (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h0B) ? 8'h1E : 8'h1F;
   endfunction
   function automatic logic [23:0] nextDate(input logic [7:0] d, m, y);
      if (d != daysIn(m, y))
         return {d + 8'h01, m, y};
      if (m != brtc_pkg::MAX_MONTH)
         return {8'h01, m + 8'h01, y};
      return {8'h01, 8'h01, (y == brtc_pkg::MAX_YEAR) ? 8'h00 : y + 8'h01};
   endfunction
   initial
   begin
      void'($urandom(89120));
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      foreach (rstOfs[i])
      begin
         rd(rstOfs[i]);
         check(q, rstVal[i]);
      end
      for (int k = 0; k < 4; k++)
      begin
         v = '{8'($urandom_range(99)), 8'($urandom_range(23)), 8'($urandom_range(59)),
            8'($urandom_range(59)), 8'($urandom_range(12, 1)), 8'($urandom_range(28, 1)),
            8'($urandom_range(99)), 8'($urandom_range(6))};
         setTime(1'b1);
         xfer(brtc_pkg::OFS_MIN, 1'b1, ~v[2], 4'hE);
         rd(brtc_pkg::OFS_HUND);
         for (int i = 0; i < 8; i++)
         begin
            rd(7'(brtc_pkg::OFS_HUND + 4 * i));
            check(q, v[i]);
         end
      end
      for (int i = 0; i < 6; i++)
      begin
         v = '{8'h63, rollH[i] ? 8'h17 : 8'h8B, 8'h3B, 8'h3B, rollM[i], rollD[i], rollY[i], 8'h03};
         setTime(rollH[i]);
         wr(brtc_pkg::OFS_RATE, 8'(i));
         wr(brtc_pkg::OFS_CLEAR, 8'h03);
         wr(brtc_pkg::OFS_ENABLE, 8'h02);
         wr(brtc_pkg::OFS_COMMAND, {4'h0, 1'b1, rollH[i], 2'h0});
         waitIrq(7000);
         rd(brtc_pkg::OFS_STATUS);
         check(q, 8'h82);
         e = nextDate(rollD[i], rollM[i], rollY[i]);
         rd(brtc_pkg::OFS_HUND);
         check(q, 8'h00);
         rd(brtc_pkg::OFS_HOUR);
         check(q, rollH[i] ? 8'h00 : brtc_pkg::NOON);
         rd(brtc_pkg::OFS_DATE);
         check(q, e[23:16]);
         rd(brtc_pkg::OFS_MONTH);
         check(q, e[15:8]);
         rd(brtc_pkg::OFS_YEAR);
         check(q, e[7:0]);
         wr(brtc_pkg::OFS_ENABLE, 8'h00);
         idle(3);
         check(irq, 1'b0);
         wr(brtc_pkg::OFS_ENABLE, 8'h02);
         idle(3);
         check(irq, 1'b1);
         wr(brtc_pkg::OFS_CLEAR, 8'h02);
         idle(3);
         check(irq, 1'b0);
      end
      v = '{8'h62, 8'h0A, 8'h14, 8'h1E, 8'h05, 8'h0F, 8'h17, 8'h02};
      setTime(1'b1);
      alm = v;
      alm[0] = 8'h02;
      alm[3] = 8'h1F;
      for (int i = 0; i < 8; i++)
         wr(7'(brtc_pkg::OFS_ALARM + 4 * i), alm[i]);
      wr(brtc_pkg::OFS_RATE, 8'h02);
      wr(brtc_pkg::OFS_CLEAR, 8'h03);
      wr(brtc_pkg::OFS_ENABLE, 8'h03);
      wr(brtc_pkg::OFS_COMMAND, 8'h0C);
      rd(brtc_pkg::OFS_HUND);
      waitIrq(7000);
      rd(brtc_pkg::OFS_SEC);
      check(q, 8'h1E);
      rd(brtc_pkg::OFS_STATUS);
      check(q, 8'h82);
      wr(brtc_pkg::OFS_CLEAR, 8'h02);
      idle(3);
      check(irq, 1'b0);
      waitIrq(7000);
      rd(brtc_pkg::OFS_STATUS);
      check(q, 8'h81);
      rd(brtc_pkg::OFS_HUND);
      check(q, 8'h02);
      rd(brtc_pkg::OFS_SEC);
      check(q, 8'h1F);
      @(posedge clk_sys);
      powerFail <= 1'b1;
      idle(5);
      wr(brtc_pkg::OFS_MIN, 8'h2A);
      rd(brtc_pkg::OFS_MIN);
      check(q | {31'h0, oe}, 32'h0);
      @(posedge clk_sys);
      powerFail <= 1'b0;
      idle(5);
      rd(brtc_pkg::OFS_HUND);
      rd(brtc_pkg::OFS_MIN);
      check(q, 8'h14);
      wr(brtc_pkg::OFS_COMMAND, 8'h1C);
      brtc_host_inst.latchAddr(brtc_pkg::OFS_MIN);
      rd(7'h7C);
      check(q, 8'h14);
      brtc_host_inst.latchAddr(brtc_pkg::OFS_COMMAND);
      wr(7'h7C, 8'h0C);
      rd(brtc_pkg::OFS_COMMAND);
      check(q, 8'h0C);
      wr(7'h60, 8'h55);
      rd(7'h60);
      check(q, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
